// >>> rtl/qdsf_defines.vh
`ifndef QDSF_DEFINES_VH
`define QDSF_DEFINES_VH

// ----------------------------------------------------------------
// serial word layout
// ----------------------------------------------------------------
`define QDSF_WORD_W        16
`define QDSF_CODE_W        12
`define QDSF_CHAN_N        4
`define QDSF_ADDR_HI       15
`define QDSF_ADDR_LO       14
`define QDSF_CMD_HI        13
`define QDSF_CMD_LO        12
`define QDSF_CODE_MSB      11
`define QDSF_BITCNT_W      5
`define QDSF_BITCNT_FULL   5'h10

// ----------------------------------------------------------------
// command codes, command_bit_hi / command_bit_lo
// ----------------------------------------------------------------
`define QDSF_CMD_LOAD_IN   2'h0
`define QDSF_CMD_LOAD_BOTH 2'h1
`define QDSF_CMD_UPD_ALL   2'h2
`define QDSF_CMD_SPECIAL   2'h3

// address field meaning under the special command
`define QDSF_SPC_NOP       2'h0
`define QDSF_SPC_MODE_FALL 2'h1
`define QDSF_SPC_MODE_RISE 2'h2
`define QDSF_SPC_LOAD_ALL  2'h3

// ----------------------------------------------------------------
// reset values and synchroniser
// ----------------------------------------------------------------
`define QDSF_EDGE_MODE_RISE 1'h1
`define QDSF_EDGE_MODE_FALL 1'h0
`define QDSF_CODE_RESET    12'h000
`define QDSF_WORD_RESET    16'h0000
`define QDSF_PIN_N         4
`define QDSF_BUF_DEPTH     2

`endif

// >>> rtl/qdsf_pair_buf.v
`timescale 1ns/1ps
`default_nettype none
`include "qdsf_defines.vh"

module qdsf_pair_buf
(
    input  wire                     i_clk,
    input  wire                     i_resetn,
    input  wire                     i_ce,
    input  wire                     i_in_valid,
    output wire                     o_in_ready,
    input  wire [`QDSF_WORD_W-1:0]  i_in_data,
    output wire                     o_out_valid,
    input  wire                     i_out_ready,
    output wire [`QDSF_WORD_W-1:0]  o_out_data
);

    reg  [`QDSF_WORD_W-1:0]  mem_reg [0:`QDSF_BUF_DEPTH-1];
    reg                      wr_ptr_reg;
    reg                      rd_ptr_reg;
    reg  [1:0]               count_reg;
    wire                     push;
    wire                     pop;

    assign o_in_ready  = (count_reg != 2'h2);
    assign o_out_valid = (count_reg != 2'h0);
    assign o_out_data  = mem_reg[rd_ptr_reg];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
            mem_reg[0] <= `QDSF_WORD_RESET;
            mem_reg[1] <= `QDSF_WORD_RESET;
        end
        else if (i_ce)
        begin
            if (push)
            begin
                mem_reg[wr_ptr_reg] <= i_in_data;
                wr_ptr_reg          <= ~wr_ptr_reg;
            end
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            if (push && !pop)
                count_reg <= count_reg + 2'h1;
            else if (pop && !push)
                count_reg <= count_reg - 2'h1;
        end
    end

endmodule
`default_nettype wire

// >>> rtl/qdsf_front_end.v
//Contract
//[R01] driving load_outputs_n low copies every input register into its converter register.
//[R02] serial_in is shifted into the 16-bit shift register on each rising shift-clock edge.
//[R03] shifting and serial_out driving happen only while chip select is low.
//[R04] the rising edge of chip select hands the word to the registers its fields select.
//[R05] serial_out presents the last stage of the shift register.
//[R06] each of four 12-bit channels has an input register and a converter register.
//[R07] each channel code is unsigned straight binary from 0 to 4095.
//[R08] a transfer is sixteen bits, msb first: address, command, then the 12-bit code.
//[R09] serial_out changes on the rising edge by default, or a half clock later once reprogrammed.
//[R10] with chip select high the interface ignores the shift clock and holds serial_out high.
//[R11] reset clears the input, converter and shift registers before any transfer.
`timescale 1ns/1ps
`default_nettype none
`include "qdsf_defines.vh"

module qdsf_front_end
(
    input  wire                     i_clk,
    input  wire                     i_resetn,
    input  wire                     i_ce,
    input  wire                     i_cs_n,
    input  wire                     i_sck,
    input  wire                     i_serial_in,
    input  wire                     i_load_outputs_n,
    input  wire                     i_apply_ready,
    output wire                     o_rx_ready,
    output reg                      o_serial_out,
    output reg                      o_serial_out_oe,
    output reg                      o_out_edge_mode,
    output wire [`QDSF_CODE_W-1:0]  o_conv_code_0,
    output wire [`QDSF_CODE_W-1:0]  o_conv_code_1,
    output wire [`QDSF_CODE_W-1:0]  o_conv_code_2,
    output wire [`QDSF_CODE_W-1:0]  o_conv_code_3
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // all four pins come from the host side, so each passes two flops
    wire [`QDSF_PIN_N-1:0]  pin_raw;
    reg  [`QDSF_PIN_N-1:0]  meta_reg;
    reg  [`QDSF_PIN_N-1:0]  sync_reg;
    reg                     sck_prev_reg;
    reg                     cs_prev_reg;

    assign pin_raw = {i_load_outputs_n, i_serial_in, i_sck, i_cs_n};

    genvar gp;
    generate
        for (gp = 0; gp < `QDSF_PIN_N; gp = gp + 1)
        begin : g_sync
            always @(posedge i_clk)
            begin
                if (!i_resetn)
                begin
                    meta_reg[gp] <= 1'b1;
                    sync_reg[gp] <= 1'b1;
                end
                else if (i_ce)
                begin
                    meta_reg[gp] <= pin_raw[gp];
                    sync_reg[gp] <= meta_reg[gp];
                end
            end
        end
    endgenerate

    wire cs_n_s    = sync_reg[0];
    wire sck_s     = sync_reg[1];
    wire din_s     = sync_reg[2];
    wire load_n_s  = sync_reg[3];

    wire sck_rise  = sck_s & ~sck_prev_reg;
    wire sck_fall  = ~sck_s & sck_prev_reg;
    wire cs_rise   = cs_n_s & ~cs_prev_reg;

    // ----------------------------------------------------------------
    // shift register and serial output
    // ----------------------------------------------------------------
    reg  [`QDSF_WORD_W-1:0]    shift_reg;
    reg  [`QDSF_BITCNT_W-1:0]  bitcnt_reg;
    reg                        echo_reg;
    wire                       word_full;
    wire                       buf_in_valid;
    wire                       buf_out_valid;
    wire                       buf_pop;
    wire [`QDSF_WORD_W-1:0]    buf_out_data;

    assign word_full    = (bitcnt_reg == `QDSF_BITCNT_FULL);
    // a short frame is dropped; a word that meets a full buffer is lost
    assign buf_in_valid = i_ce & cs_rise & word_full; // [R04] [R08]

    always @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            sck_prev_reg    <= 1'b1;
            cs_prev_reg     <= 1'b1;
            shift_reg       <= `QDSF_WORD_RESET; // [R11]
            bitcnt_reg      <= {`QDSF_BITCNT_W{1'b0}};
            echo_reg        <= 1'b1;
            o_serial_out    <= 1'b1;
            o_serial_out_oe <= 1'b0;
        end
        else if (i_ce)
        begin
            sck_prev_reg    <= sck_s;
            cs_prev_reg     <= cs_n_s;
            o_serial_out_oe <= ~cs_n_s; // [R03]
            if (cs_n_s)
            begin
                // shift-clock edges are ignored while deselected
                bitcnt_reg   <= {`QDSF_BITCNT_W{1'b0}};
                o_serial_out <= 1'b1; // [R10]
                echo_reg     <= 1'b1;
            end
            else
            begin
                if (sck_rise)
                begin
                    shift_reg <= {shift_reg[`QDSF_WORD_W-2:0], din_s}; // [R02] [R03]
                    echo_reg  <= shift_reg[`QDSF_WORD_W-1]; // [R05]
                    if (!word_full)
                        bitcnt_reg <= bitcnt_reg + 5'h01;
                    if (o_out_edge_mode == `QDSF_EDGE_MODE_RISE)
                        o_serial_out <= shift_reg[`QDSF_WORD_W-1]; // [R09]
                end
                // falling mode re-times the echoed bit half a clock later
                if (sck_fall && (o_out_edge_mode == `QDSF_EDGE_MODE_FALL))
                    o_serial_out <= echo_reg; // [R09]
            end
        end
    end

    // ----------------------------------------------------------------
    // word buffer
    // ----------------------------------------------------------------
    // the register update side may stall, so two words can wait here
    qdsf_pair_buf u_buf
    (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_ce        (i_ce),
        .i_in_valid  (buf_in_valid),
        .o_in_ready  (o_rx_ready),
        .i_in_data   (shift_reg),
        .o_out_valid (buf_out_valid),
        .i_out_ready (i_apply_ready),
        .o_out_data  (buf_out_data)
    );

    assign buf_pop = buf_out_valid & i_apply_ready;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    wire [1:0]               w_addr = buf_out_data[`QDSF_ADDR_HI:`QDSF_ADDR_LO]; // [R08]
    wire [1:0]               w_cmd  = buf_out_data[`QDSF_CMD_HI:`QDSF_CMD_LO];
    // unsigned straight binary, stored as is
    wire [`QDSF_CODE_W-1:0]  w_code = buf_out_data[`QDSF_CODE_MSB:0]; // [R07]
    wire                     is_spc = (w_cmd == `QDSF_CMD_SPECIAL);
    wire                     do_update_all;
    wire                     do_load_all;

    assign do_update_all = buf_pop & ((w_cmd == `QDSF_CMD_UPD_ALL) |
                           (is_spc & ((w_addr == `QDSF_SPC_MODE_FALL) |
                                      (w_addr == `QDSF_SPC_MODE_RISE))));
    assign do_load_all   = buf_pop & is_spc & (w_addr == `QDSF_SPC_LOAD_ALL);

    always @(posedge i_clk)
    begin
        if (!i_resetn)
            o_out_edge_mode <= `QDSF_EDGE_MODE_RISE; // [R09]
        else if (i_ce && buf_pop && is_spc)
        begin
            if (w_addr == `QDSF_SPC_MODE_FALL)
                o_out_edge_mode <= `QDSF_EDGE_MODE_FALL;
            else if (w_addr == `QDSF_SPC_MODE_RISE)
                o_out_edge_mode <= `QDSF_EDGE_MODE_RISE;
        end
    end

    // ----------------------------------------------------------------
    // per-channel double buffer
    // ----------------------------------------------------------------
    reg  [`QDSF_CODE_W-1:0]  in_reg   [0:`QDSF_CHAN_N-1]; // [R06]
    reg  [`QDSF_CODE_W-1:0]  conv_reg [0:`QDSF_CHAN_N-1]; // [R06]

    genvar gc;
    generate
        for (gc = 0; gc < `QDSF_CHAN_N; gc = gc + 1)
        begin : g_chan
            wire hit = buf_pop & ({30'h0, w_addr} == gc) & ~is_spc &
                       (w_cmd != `QDSF_CMD_UPD_ALL);
            always @(posedge i_clk)
            begin
                if (!i_resetn)
                begin
                    in_reg[gc]   <= `QDSF_CODE_RESET; // [R11]
                    conv_reg[gc] <= `QDSF_CODE_RESET; // [R11]
                end
                else if (i_ce)
                begin
                    // the load pin acts as a level, independent of shift-clock timing
                    if (!load_n_s || do_update_all)
                        conv_reg[gc] <= in_reg[gc]; // [R01]
                    if (hit || do_load_all)
                        in_reg[gc] <= w_code; // [R04]
                    if ((hit && (w_cmd == `QDSF_CMD_LOAD_BOTH)) || do_load_all)
                        conv_reg[gc] <= w_code; // [R04]
                end
            end
        end
    endgenerate

    assign o_conv_code_0 = conv_reg[0];
    assign o_conv_code_1 = conv_reg[1];
    assign o_conv_code_2 = conv_reg[2];
    assign o_conv_code_3 = conv_reg[3];

endmodule
`default_nettype wire

// >>> dv/qdsf_front_end_checker.sv
`timescale 1ns/1ps
`default_nettype none
module qdsf_front_end_checker
(
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic        i_ce,
    input wire logic        i_cs_n,
    input wire logic        i_sck,
    input wire logic        i_load_outputs_n,
    input wire logic        i_apply_ready,
    input wire logic        o_serial_out,
    input wire logic        o_serial_out_oe,
    input wire logic        o_out_edge_mode,
    input wire logic [11:0] o_conv_code_0,
    input wire logic [11:0] o_conv_code_1,
    input wire logic [11:0] o_conv_code_2,
    input wire logic [11:0] o_conv_code_3
);
    // ----------------------------------------------------------------
    // port relations; the pins pass a two-flop synchroniser first
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    idle_out_high_a: assert property (!o_serial_out_oe |-> o_serial_out)
        else $error("serial out not high while deselected");
    select_drive_a: assert property ($fell(i_cs_n) |-> ##[1:4] o_serial_out_oe)
        else $error("serial out not enabled after select");
    deselect_release_a: assert property ($rose(i_cs_n) |-> ##[1:4] !o_serial_out_oe)
        else $error("serial out still enabled after deselect");
    reset_clear_a: assert property (disable iff (1'b0) (!i_resetn && i_ce) |=>
        (o_out_edge_mode && o_serial_out && !o_serial_out_oe && o_conv_code_0 == 12'h000
        && o_conv_code_1 == 12'h000 && o_conv_code_2 == 12'h000 && o_conv_code_3 == 12'h000))
        else $error("reset values wrong");
    conv_hold_a: assert property ((i_load_outputs_n && !i_apply_ready)[*4] |=>
        $stable({o_conv_code_0, o_conv_code_1, o_conv_code_2, o_conv_code_3}))
        else $error("converter changed without a cause");
    mode_apply_a: assert property ($changed(o_out_edge_mode) |-> $past(i_apply_ready))
        else $error("output edge mode changed without an applied word");
    // changes within two cycles of select are skipped; the old msb on the first rise is still checked
    rise_shift_a: assert property (($changed(o_serial_out) && o_out_edge_mode
        && o_serial_out_oe && $past(o_serial_out_oe) && $past(o_serial_out_oe, 2))
        |-> $past(i_sck, 2))
        else $error("serial out moved away from a rising shift edge");
    fall_shift_a: assert property (($changed(o_serial_out) && !o_out_edge_mode
        && o_serial_out_oe
        && $past(o_serial_out_oe) && $past(o_serial_out_oe, 2)) |-> !$past(i_sck, 2))
        else $error("serial out moved away from a falling shift edge");
endmodule
bind qdsf_front_end qdsf_front_end_checker i_chk
(
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_cs_n(i_cs_n), .i_sck(i_sck),
    .i_load_outputs_n(i_load_outputs_n), .i_apply_ready(i_apply_ready),
    .o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe),
    .o_out_edge_mode(o_out_edge_mode),
    .o_conv_code_0(o_conv_code_0), .o_conv_code_1(o_conv_code_1),
    .o_conv_code_2(o_conv_code_2), .o_conv_code_3(o_conv_code_3)
);
`default_nettype wire

// >>> dv/qdsf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module qdsf_host_model
(
    input  wire logic i_clk,
    input  wire logic i_serial_out,
    output var  logic o_cs_n,
    output var  logic o_sck,
    output var  logic o_serial_in
);
    // ----------------------------------------------------------------
    // serial master: shift clock stands low outside frames except during idle_clocks, 8 clk period
    // ----------------------------------------------------------------
    initial
    begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_serial_in = 1'b0;
    end
    task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] echo);
        echo = 16'h0000;
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            o_serial_in <= word[15 - i];
            repeat (4) @(posedge i_clk);
            o_sck <= 1'b1;
            repeat (4) @(posedge i_clk);
            // in rising mode the block moves serial out on the rise, so take it just before the fall
            echo = {echo[14:0], i_serial_out};
            o_sck <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
        o_cs_n <= 1'b1;
        // a released data line must not keep looking valid
        o_serial_in <= ~o_serial_in;
        repeat (4) @(posedge i_clk);
    endtask
    // shift clock left running while deselected; the block must ignore it
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++)
        begin
            o_serial_in <= ~o_serial_in;
            o_sck <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_sck <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
    endtask
endmodule
`default_nettype wire

// >>> dv/qdsf_front_end_test.sv
`timescale 1ns/1ps
`default_nettype none
module qdsf_front_end_test;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        load_n = 1'b1;
    logic        apply_ready = 1'b1;
    logic [15:0] echo;
    int          errors = 0;
    int          cmp_count = 0;
    wire         cs_n, sck, sin, rx_ready, sout, sout_oe, mode;
    wire  [11:0] conv [0:3];
    // tri-state pin with pull-up: pulled high whenever the block lets go
    wire         sout_pin = sout_oe ? sout : 1'b1;
    always #20 clk = ~clk;
    qdsf_front_end i_qdsf_front_end
    (
        .i_clk(clk), .i_resetn(resetn), .i_ce(1'b1), .i_cs_n(cs_n), .i_sck(sck),
        .i_serial_in(sin), .i_load_outputs_n(load_n), .i_apply_ready(apply_ready),
        .o_rx_ready(rx_ready), .o_serial_out(sout), .o_serial_out_oe(sout_oe),
        .o_out_edge_mode(mode),
        .o_conv_code_0(conv[0]), .o_conv_code_1(conv[1]), .o_conv_code_2(conv[2]),
        .o_conv_code_3(conv[3])
    );
    qdsf_host_model i_qdsf_host_model
    (
        .i_clk(clk), .i_serial_out(sout_pin), .o_cs_n(cs_n), .o_sck(sck), .o_serial_in(sin)
    );
    // ----------------------------------------------------------------
    // shared tasks and scenarios
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [15:0] w, input int n);
        i_qdsf_host_model.xfer(w, n, echo);
        repeat (6) @(posedge clk);
    endtask
    task automatic t_reset;
        chk({12'h000, mode, sout, sout_oe, rx_ready}, 16'h000D);
        for (int a = 0; a < 4; a++)
            chk({4'h0, conv[a]}, 16'h0000);
        // a load pulse must find input register 3 cleared as well
        load_n <= 1'b0;
        repeat (4) @(posedge clk);
        load_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({4'h0, conv[3]}, 16'h0000);
        send(16'h0000, 16);
        chk(echo, 16'h0000);
    endtask
    task automatic t_load_both;
        logic [11:0] codes [0:3];
        codes = '{12'hFFF, 12'h001, 12'h800, 12'hA5A};
        for (int a = 0; a < 4; a++)
        begin
            send({a[1:0], 2'b01, codes[a]}, 16);
            chk({4'h0, conv[a]}, {4'h0, codes[a]});
        end
    endtask
    task automatic t_double_buffer;
        send({2'b10, 2'b00, 12'h123}, 16);
        chk({4'h0, conv[2]}, 16'h0800);
        load_n <= 1'b0;
        repeat (4) @(posedge clk);
        load_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({4'h0, conv[2]}, 16'h0123);
        send({2'b11, 2'b00, 12'h321}, 16);
        send({2'b00, 2'b10, 12'h000}, 16);
        chk({4'h0, conv[3]}, 16'h0321);
    endtask
    task automatic t_special;
        send({2'b01, 2'b11, 12'h000}, 16);
        chk({15'h0, mode}, 16'h0000);
        send({2'b10, 2'b11, 12'h000}, 16);
        chk({15'h0, mode}, 16'h0001);
        send({2'b00, 2'b11, 12'h777}, 16);
        chk({4'h0, conv[0]}, 16'h0FFF);
        send({2'b11, 2'b11, 12'h456}, 16);
        for (int a = 0; a < 4; a++)
            chk({4'h0, conv[a]}, 16'h0456);
    endtask
    task automatic t_echo_short;
        send(16'hC3A5, 16);
        // shift clock toggling while deselected must leave the word alone
        i_qdsf_host_model.idle_clocks(3);
        send(16'h3010, 16);
        chk(echo, 16'hC3A5);
        // were the cut frame taken, channel 0 would get 01F in both registers
        send(16'h1FFF, 8);
        chk({4'h0, conv[0]}, 16'h0456);
    endtask
    task automatic t_stall;
        apply_ready <= 1'b0;
        send({2'b01, 2'b01, 12'hAAA}, 16);
        send({2'b01, 2'b01, 12'hBBB}, 16);
        chk({15'h0, rx_ready}, 16'h0000);
        chk({4'h0, conv[1]}, 16'h0456);
        send({2'b01, 2'b01, 12'hCCC}, 16);
        apply_ready <= 1'b1;
        repeat (4) @(posedge clk);
        chk({4'h0, conv[1]}, 16'h0BBB);
        chk({15'h0, rx_ready}, 16'h0001);
    endtask
    task automatic final_report;
        if (errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_load_both();
        t_double_buffer();
        t_special();
        t_echo_short();
        t_stall();
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        final_report();
    end
endmodule
`default_nettype wire
